// ---- design/agh_consts.svh ----
/*
 * Register offsets, field positions and reset values of the gate and
 * headroom configuration bank, plus a short description of its behaviour.
 * Assumes inclusion by bare name from the register bank design file.
 */
// How it works
// [R1] Bits 7-6 of the switch/headroom register pick the bridge switching delay; codes 0-3 give 8.1/7.1/6.1/5.6 periods at 48 ksps with the gate on and 6.1/5.1/4.1/3.6 with it off.
// [R2] At 96 ksps the same codes give 12.6/10.6/8.5/7.6 with the gate on and 9.6/7.6/5.6/4.6 with it off.
// [R3] Bits 3-0 of that register set the headroom threshold below the battery supply, 0.5 V at code 0 rising 0.1 V a code to 2 V at code 15.
// [R4] With the brownout source on the power-stage supply, bit 6 of the gate mode register makes the converter also sample the battery, and 0 means no battery conversion.
// [R5] Bit 2 of the gate mode register turns the fine-resolution gate on at 1 and off at 0, and resets to 0.
// [R6] Three registers give bits 23:16, 15:8 and 7:0 of the 24-bit fine gate level, a linear gain scaled by 2^23.
// [R7] After reset the fine gate level stands at the value for -110 dBFS.
// [R8] The fine gate hold is a 19-bit count of ms times kHz, two registers giving bits 18:11 and 10:3 with the low three bits zero.
// [R9] Software should set the fine gate hold above one millisecond; the hardware does not enforce it.
// [R10] Bits 5-0 of the lockout register select the power-stage lockout level, 1.753 V at 00h, 2.09 V at 01h, 2.428 V at 02h and upward.
// [R11] With the multi-level bridge in use, software keeps the lockout level at least 2.5 V above the battery supply.
// [R12] Read-only bits 7-6 of the shaping register report the element-matching state: 0 both on, 1 LSB off, 2 MSB off, 3 both off.
// [R13] Bit 5 of the shaping register keeps dither on at 0 and disables it at 1, and resets to 0.
// [R14] Writes leave read-only bits unchanged, and reads return current fields with reserved read-only bits at their reset values.
`ifndef AGH_CONSTS_SVH
`define AGH_CONSTS_SVH

// Register indexes; the bus byte address is four times the index
`define AGH_OFF_SWHR      8'h6A
`define AGH_OFF_GMODE     8'h6B
`define AGH_OFF_LVL_HI    8'h6C
`define AGH_OFF_LVL_MID   8'h6D
`define AGH_OFF_LVL_LO    8'h6E
`define AGH_OFF_HOLD_HI   8'h6F
`define AGH_OFF_HOLD_LO   8'h70
`define AGH_OFF_LOCKOUT   8'h71
`define AGH_OFF_SHAPING   8'h73

// Reset values
`define AGH_RST_SWHR      8'h12
`define AGH_RST_GMODE     8'h43
`define AGH_RST_LVL_HI    8'h00
`define AGH_RST_LVL_MID   8'h00
`define AGH_RST_LVL_LO    8'h1A
`define AGH_RST_HOLD_HI   8'h00
`define AGH_RST_HOLD_LO   8'h96
`define AGH_RST_LOCKOUT   8'h02
`define AGH_RST_SHAPING   8'h00

// Writable bit masks per register; other bits hold their reset value
`define AGH_WMASK_SWHR    8'hFF
`define AGH_WMASK_GMODE   8'h7F
`define AGH_WMASK_FULL    8'hFF
`define AGH_WMASK_LOCKOUT 8'hFF
`define AGH_WMASK_SHAPING 8'h20

// Field positions
`define AGH_SWDLY_HI      7
`define AGH_SWDLY_LO      6
`define AGH_HEAD_HI       3
`define AGH_HEAD_LO       0
`define AGH_BATT_BIT      6
`define AGH_FINE_BIT      2
`define AGH_LOCK_HI       5
`define AGH_LOCK_LO       0
`define AGH_DEM_HI        7
`define AGH_DEM_LO        6
`define AGH_DITH_BIT      5
`define AGH_HOLD_PAD      3'h0

// Bus answers
`define AGH_RESP_OKAY     2'h0
`define AGH_RESP_SLVERR   2'h2

`endif

// ---- design/agh_pkg.sv ----
/*
 * Types shared by the gate and headroom configuration bank.
 * Assumes agh_consts.svh is on the include path.
 */
package agh_pkg;

	// Fields decoded from the bank for the amplifier datapath
	typedef struct packed {
		logic [1:0]  bridge_switch_delay;
		logic [3:0]  low_signal_headroom_threshold;
		logic        battery_sample_enable;
		logic        gate_fine_mode_enable;
		logic [23:0] gate_fine_level;
		logic [18:0] gate_fine_hold;
		logic [5:0]  power_stage_lockout_level;
		logic        dither_disable;
	} agh_cfg_t;

	// Delay of the bridge in tenths of a sample period
	typedef logic [7:0] agh_tenths_t;

endpackage

// ---- design/agh_byte_reg.sv ----
/*
 * One byte-wide configuration register with a per-bit write mask.
 * Assumes a synchronous, active-low reset and a one-cycle write strobe.
 */
`timescale 1ns/1ps
module agh_byte_reg
#(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] WMASK     = 8'hFF
)
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       we_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] value_o
);

	logic [7:0] value_q;
	logic [7:0] value_d;

	// Masked bits take new data, others keep their value
	assign value_d = we_i ? ((wdata_i & WMASK) | (value_q & ~WMASK))
	                      : value_q; // see [R14]
	assign value_o = value_q;

	// Storage
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			value_q <= RESET_VAL;
		else
			value_q <= value_d;
	end

endmodule

// ---- design/agh_cfg_regs.sv ----
/*
 * Gate, headroom and supply configuration bank behind an AXI4-Lite slave.
 * Assumes a single 200 MHz clock, synchronous active-low reset, and that
 * the datapath provides the element-matching state and the sample rate.
 * Each byte register sits in the low lane of its own 32-bit word, at a
 * byte address four times its index; any other address answers SLVERR.
 * A write is answered two cycles after the later of its two channels is
 * taken, and a read one cycle after its address is taken.
 */
`timescale 1ns/1ps
`include "agh_consts.svh"
module agh_cfg_regs
	import agh_pkg::*;
(
	// Clock and reset
	input  wire logic         CLOCK_I,
	input  wire logic         RST_N_I,
	// Write address channel
	input  wire logic [9:0]   AWADDR_I,
	input  wire logic         AWVALID_I,
	output logic              AWREADY_O,
	// Write data channel
	input  wire logic [31:0]  WDATA_I,
	input  wire logic [3:0]   WSTRB_I,
	input  wire logic         WVALID_I,
	output logic              WREADY_O,
	// Write response channel
	output logic [1:0]        BRESP_O,
	output logic              BVALID_O,
	input  wire logic         BREADY_I,
	// Read address channel
	input  wire logic [9:0]   ARADDR_I,
	input  wire logic         ARVALID_I,
	output logic              ARREADY_O,
	// Read data channel
	output logic [31:0]       RDATA_O,
	output logic [1:0]        RRESP_O,
	output logic              RVALID_O,
	input  wire logic         RREADY_I,
	// Datapath status
	input  wire logic [1:0]   ELEMENT_MATCHING_STATE_I,
	input  wire logic         RATE_96K_I,
	input  wire logic         BROWNOUT_SRC_POWER_STAGE_I,
	// Configuration toward the datapath
	output agh_cfg_t          CFG_O,
	output agh_tenths_t       BRIDGE_DELAY_TENTHS_O,
	output logic              BATTERY_CONVERT_O
);

	localparam int NREG = 9;

	typedef enum logic [2:0] {
		WR_IDLE = 3'b001,
		WR_HAVE = 3'b010,
		WR_RESP = 3'b100
	} agh_wr_st_t;

	agh_wr_st_t  wst_q;
	agh_wr_st_t  wst_d;
	logic        aw_got_q;
	logic        w_got_q;
	logic [9:0]  waddr_q;
	logic [7:0]  wbyte_q;
	logic        wlane_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [1:0]  rresp_q;
	logic [31:0] rdata_q;
	logic [7:0]  reg_val [NREG];
	logic [NREG-1:0] we;
	logic [7:0]  rd_byte;
	logic        rd_hit;
	logic        wr_hit;
	logic        aw_take;
	logic        w_take;
	logic        do_write;
	logic        ar_take;
	logic        rd_shaping;
	logic [31:0] rd_word;

	// Register indexes in table order
	localparam logic [7:0] OFFS [NREG] = '{
		`AGH_OFF_SWHR,     // Switch delay and headroom
		`AGH_OFF_GMODE,    // Gate mode
		`AGH_OFF_LVL_HI,   // Fine level, top byte
		`AGH_OFF_LVL_MID,  // Fine level, middle byte
		`AGH_OFF_LVL_LO,   // Fine level, low byte
		`AGH_OFF_HOLD_HI,  // Fine hold, top byte
		`AGH_OFF_HOLD_LO,  // Fine hold, low byte
		`AGH_OFF_LOCKOUT,  // Power-stage lockout
		`AGH_OFF_SHAPING   // Converter shaping
	};

	// Reset values in the same order
	localparam logic [7:0] RSTV [NREG] = '{
		`AGH_RST_SWHR,
		`AGH_RST_GMODE,
		`AGH_RST_LVL_HI,
		`AGH_RST_LVL_MID,
		`AGH_RST_LVL_LO,
		`AGH_RST_HOLD_HI,
		`AGH_RST_HOLD_LO,
		`AGH_RST_LOCKOUT,
		`AGH_RST_SHAPING
	};

	// Writable bits; the rest hold their reset value
	localparam logic [7:0] MSKV [NREG] = '{
		`AGH_WMASK_SWHR,
		`AGH_WMASK_GMODE,   // Top bit read-only
		`AGH_WMASK_FULL,
		`AGH_WMASK_FULL,
		`AGH_WMASK_FULL,
		`AGH_WMASK_FULL,
		`AGH_WMASK_FULL,
		`AGH_WMASK_LOCKOUT,
		`AGH_WMASK_SHAPING  // Dither bit only
	};

	// Write channel handshakes: each channel is taken once per write
	assign AWREADY_O = (wst_q != WR_RESP) && !aw_got_q;
	assign WREADY_O  = (wst_q != WR_RESP) && !w_got_q;
	assign aw_take   = AWVALID_I && AWREADY_O;
	assign w_take    = WVALID_I && WREADY_O;
	assign do_write  = (wst_q == WR_HAVE) && aw_got_q && w_got_q;

	// Write sequencer state
	always_comb
	begin
		wst_d = wst_q;
		case (wst_q)
			WR_IDLE: if (aw_take || w_take) wst_d = WR_HAVE;
			WR_HAVE: if (aw_got_q && w_got_q) wst_d = WR_RESP;
			WR_RESP: if (BREADY_I) wst_d = WR_IDLE;
			default: wst_d = WR_IDLE;
		endcase
	end

	// Address and data capture; only the addressed lane of the word counts
	always_ff @(posedge CLOCK_I)
	begin
		if (!RST_N_I)
		begin
			wst_q    <= WR_IDLE;
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			waddr_q  <= 10'h000;
			wbyte_q  <= 8'h00;
			wlane_q  <= 1'b0;
		end
		else
		begin
			wst_q <= wst_d;
			if (aw_take)
				waddr_q <= AWADDR_I;
			if (w_take)
			begin
				wbyte_q <= WDATA_I[7:0];
				wlane_q <= WSTRB_I[0];
			end
			aw_got_q <= do_write ? 1'b0 : (aw_got_q || aw_take);
			w_got_q  <= do_write ? 1'b0 : (w_got_q || w_take);
		end
	end

	// Per-register write enables and read mux
	always_comb
	begin
		rd_byte = 8'h00;
		rd_hit  = 1'b0;
		wr_hit  = 1'b0;
		we      = '0;
		for (int i = 0; i < NREG; i++)
		begin
			if (waddr_q == {OFFS[i], 2'b00})
			begin
				wr_hit = 1'b1;
				we[i]  = do_write && wlane_q;
			end
			if (ARADDR_I == {OFFS[i], 2'b00})
			begin
				rd_hit  = 1'b1;
				rd_byte = reg_val[i];
			end
		end
	end

	// Register storage, one masked byte each
	for (genvar g = 0; g < NREG; g++)
	begin : g_reg
		agh_byte_reg #(
			.RESET_VAL (RSTV[g]),
			.WMASK     (MSKV[g])
		) u_reg (
			.clk_i   (CLOCK_I),
			.rst_n_i (RST_N_I),
			.we_i    (we[g]),
			.wdata_i (wbyte_q),
			.value_o (reg_val[g])
		);
	end

	// Write response, OKAY on a mapped byte, SLVERR otherwise
	always_ff @(posedge CLOCK_I)
	begin
		if (!RST_N_I)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= `AGH_RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? `AGH_RESP_OKAY : `AGH_RESP_SLVERR;
		end
		else if (bvalid_q && BREADY_I)
			bvalid_q <= 1'b0;
	end

	assign BVALID_O = bvalid_q;
	assign BRESP_O  = bresp_q;

	// Read channel: address taken when no answer is pending
	assign ARREADY_O = !rvalid_q;
	assign ar_take   = ARVALID_I && ARREADY_O;

	// Read word; the shaping byte shows the live matching state in 7-6
	assign rd_shaping = (ARADDR_I == {`AGH_OFF_SHAPING, 2'b00});
	assign rd_word    = {24'h00_0000, rd_shaping
		? {ELEMENT_MATCHING_STATE_I, rd_byte[5:0]}
		: rd_byte}; // see [R12] see [R14]

	// Read answer, held until the master takes it
	always_ff @(posedge CLOCK_I)
	begin
		if (!RST_N_I)
		begin
			rvalid_q <= 1'b0;
			rresp_q  <= `AGH_RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
		end
		else if (ar_take)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= rd_hit ? `AGH_RESP_OKAY : `AGH_RESP_SLVERR;
			rdata_q  <= rd_word;
		end
		else if (rvalid_q && RREADY_I)
			rvalid_q <= 1'b0;
	end

	assign RVALID_O = rvalid_q;
	assign RRESP_O  = rresp_q;
	assign RDATA_O  = rdata_q;

	// Field extraction toward the datapath, one driver for the struct
	assign CFG_O = '{
		bridge_switch_delay:
			reg_val[0][`AGH_SWDLY_HI:`AGH_SWDLY_LO], // see [R1]
		low_signal_headroom_threshold:
			reg_val[0][`AGH_HEAD_HI:`AGH_HEAD_LO], // see [R3]
		battery_sample_enable:
			reg_val[1][`AGH_BATT_BIT],
		gate_fine_mode_enable:
			reg_val[1][`AGH_FINE_BIT], // see [R5]
		gate_fine_level:
			{reg_val[2], reg_val[3], reg_val[4]}, // see [R6] see [R7]
		gate_fine_hold:
			{reg_val[5], reg_val[6], `AGH_HOLD_PAD}, // see [R8]
		power_stage_lockout_level:
			reg_val[7][`AGH_LOCK_HI:`AGH_LOCK_LO], // see [R10]
		dither_disable:
			reg_val[8][`AGH_DITH_BIT] // see [R13]
	};

	// Battery conversion only with power-stage brownout source
	assign BATTERY_CONVERT_O = BROWNOUT_SRC_POWER_STAGE_I
		&& reg_val[1][`AGH_BATT_BIT]; // see [R4]

	// Bridge delay lookup in tenths of a sample period
	always_comb
	begin
		case ({RATE_96K_I, reg_val[1][`AGH_FINE_BIT],
			reg_val[0][`AGH_SWDLY_HI:`AGH_SWDLY_LO]})
			4'h0: BRIDGE_DELAY_TENTHS_O = 8'd61; // see [R1]
			4'h1: BRIDGE_DELAY_TENTHS_O = 8'd51;
			4'h2: BRIDGE_DELAY_TENTHS_O = 8'd41;
			4'h3: BRIDGE_DELAY_TENTHS_O = 8'd36;
			4'h4: BRIDGE_DELAY_TENTHS_O = 8'd81;
			4'h5: BRIDGE_DELAY_TENTHS_O = 8'd71;
			4'h6: BRIDGE_DELAY_TENTHS_O = 8'd61;
			4'h7: BRIDGE_DELAY_TENTHS_O = 8'd56;
			4'h8: BRIDGE_DELAY_TENTHS_O = 8'd96; // see [R2]
			4'h9: BRIDGE_DELAY_TENTHS_O = 8'd76;
			4'hA: BRIDGE_DELAY_TENTHS_O = 8'd56;
			4'hB: BRIDGE_DELAY_TENTHS_O = 8'd46;
			4'hC: BRIDGE_DELAY_TENTHS_O = 8'd126;
			4'hD: BRIDGE_DELAY_TENTHS_O = 8'd106;
			4'hE: BRIDGE_DELAY_TENTHS_O = 8'd85;
			4'hF: BRIDGE_DELAY_TENTHS_O = 8'd76;
			default: BRIDGE_DELAY_TENTHS_O = 8'd61;
		endcase
	end

endmodule

// ---- verif/agh_cfg_regs_chk.sv ----
/* Port assertions for the gate and headroom configuration bank.
   Assumes it is bound onto agh_cfg_regs with one clock domain. */
`timescale 1ns/1ps
module agh_cfg_regs_chk
	import agh_pkg::*;
(
	input wire logic        CLOCK_I,
	input wire logic        RST_N_I,
	input wire logic        AWVALID_I,
	input wire logic        AWREADY_O,
	input wire logic        WVALID_I,
	input wire logic        WREADY_O,
	input wire logic [1:0]  BRESP_O,
	input wire logic        BVALID_O,
	input wire logic        BREADY_I,
	input wire logic        ARVALID_I,
	input wire logic        ARREADY_O,
	input wire logic [31:0] RDATA_O,
	input wire logic        RVALID_O,
	input wire logic        RREADY_I,
	input wire logic        RATE_96K_I,
	input wire logic        BROWNOUT_SRC_POWER_STAGE_I,
	input wire agh_cfg_t    CFG_O,
	input wire agh_tenths_t BRIDGE_DELAY_TENTHS_O,
	input wire logic        BATTERY_CONVERT_O
);
	// Delay in tenths, indexed by rate, fine mode, code
	localparam logic [7:0] DLY [16] = '{8'h3D, 8'h33, 8'h29, 8'h24,
		8'h51, 8'h47, 8'h3D, 8'h38, 8'h60, 8'h4C, 8'h38, 8'h2E,
		8'h7E, 8'h6A, 8'h55, 8'h4C};
	wire logic [3:0] dly_idx;
	assign dly_idx = {RATE_96K_I, CFG_O.gate_fine_mode_enable,
		CFG_O.bridge_switch_delay};

	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);

	// Datapath outputs against the register fields
	property p_delay; BRIDGE_DELAY_TENTHS_O == DLY[dly_idx]; endproperty
	a_delay: assert property (p_delay)
		else $error("bridge delay lookup wrong");
	property p_batt; BATTERY_CONVERT_O == (BROWNOUT_SRC_POWER_STAGE_I
		&& CFG_O.battery_sample_enable); endproperty
	a_batt: assert property (p_batt)
		else $error("battery conversion enable wrong");
	property p_pad; CFG_O.gate_fine_hold[2:0] == 3'h0; endproperty
	a_pad: assert property (p_pad)
		else $error("hold low bits not zero");
	property p_rst; $rose(RST_N_I) |-> CFG_O.gate_fine_level == 24'h00001A
		&& !CFG_O.gate_fine_mode_enable && !CFG_O.dither_disable
		&& CFG_O.power_stage_lockout_level == 6'h02; endproperty
	a_rst: assert property (p_rst)
		else $error("fields not at reset values");

	// Bus handshake timing
	property p_wlat; AWVALID_I && AWREADY_O && WVALID_I && WREADY_O
		|=> ##1 BVALID_O; endproperty
	a_wlat: assert property (p_wlat)
		else $error("write response late");
	property p_bhold; BVALID_O && !BREADY_I |=> BVALID_O
		&& $stable(BRESP_O); endproperty
	a_bhold: assert property (p_bhold)
		else $error("write response dropped");
	property p_rlat; ARVALID_I && ARREADY_O |=> RVALID_O
		&& RDATA_O[31:8] == 24'h0; endproperty
	a_rlat: assert property (p_rlat)
		else $error("read response late or wide");
	property p_rhold; RVALID_O && !RREADY_I |=> RVALID_O
		&& $stable(RDATA_O); endproperty
	a_rhold: assert property (p_rhold)
		else $error("read data dropped");
	property p_bblock; BVALID_O |-> !AWREADY_O && !WREADY_O; endproperty
	a_bblock: assert property (p_bblock)
		else $error("write taken during response");
endmodule

bind agh_cfg_regs agh_cfg_regs_chk i_chk (.CLOCK_I(CLOCK_I),
	.RST_N_I(RST_N_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
	.WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O),
	.BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I),
	.ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O),
	.RREADY_I(RREADY_I), .RATE_96K_I(RATE_96K_I), .CFG_O(CFG_O),
	.BROWNOUT_SRC_POWER_STAGE_I(BROWNOUT_SRC_POWER_STAGE_I),
	.BRIDGE_DELAY_TENTHS_O(BRIDGE_DELAY_TENTHS_O),
	.BATTERY_CONVERT_O(BATTERY_CONVERT_O));

// ---- verif/agh_cfg_regs_test.sv ----
/* Self-checking bench for the gate and headroom configuration bank.
   Assumes the package, design and checker are compiled first. */
`timescale 1ns/1ps
module agh_cfg_regs_test import agh_pkg::*;;
	logic clk, rst_n, awv, wv, bready, arv, rready, rate, bsrc;
	logic [9:0] awa, ara;
	logic [31:0] wd;
	logic [3:0] ws;
	logic [1:0] ems;
	wire logic awr, wrdy, bv, arr, rv, batt;
	wire logic [1:0] br, rr;
	wire logic [31:0] rd;
	wire agh_cfg_t cfg;
	wire agh_tenths_t dly;
	int fail_count, samples_checked, cyc = 0;
	logic [7:0] ad_t [9] = '{8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h6F,
		8'h70, 8'h71, 8'h73};
	logic [7:0] rs_t [9] = '{8'h12, 8'h43, 8'h00, 8'h00, 8'h1A, 8'h00,
		8'h96, 8'h02, 8'h00};
	logic [7:0] mk_t [9] = '{8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'h20};
	logic [7:0] dl_t [16] = '{8'h3D, 8'h33, 8'h29, 8'h24, 8'h51, 8'h47,
		8'h3D, 8'h38, 8'h60, 8'h4C, 8'h38, 8'h2E, 8'h7E, 8'h6A, 8'h55,
		8'h4C};

	agh_cfg_regs i_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .AWADDR_I(awa),
		.AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(ws),
		.WVALID_I(wv), .WREADY_O(wrdy), .BRESP_O(br), .BVALID_O(bv),
		.BREADY_I(bready), .ARADDR_I(ara), .ARVALID_I(arv),
		.ARREADY_O(arr), .RDATA_O(rd), .RRESP_O(rr), .RVALID_O(rv),
		.RREADY_I(rready), .ELEMENT_MATCHING_STATE_I(ems),
		.RATE_96K_I(rate), .BROWNOUT_SRC_POWER_STAGE_I(bsrc),
		.CFG_O(cfg), .BRIDGE_DELAY_TENTHS_O(dly), .BATTERY_CONVERT_O(batt));

	// Clock and hang guard
	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			fail_count++;
			close_out;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Write one byte to register index a; the word address is a times four
	task automatic bus_wr(input logic [7:0] a, d, input logic [1:0] er);
		awa <= {a, 2'b00};
		wd <= {24'h0, d};
		awv <= 1;
		wv <= 1;
		do
		begin
			@(posedge clk);
			if (awr) awv <= 0;
			if (wrdy) wv <= 0;
		end
		while (awv || wv);
		do @(posedge clk); while (bv !== 1'b1);
		bready <= 1;
		@(posedge clk);
		bready <= 0;
		chk({30'h0, br}, {30'h0, er});
	endtask

	// Read the word of register index a and compare data and response
	task automatic rd_exp(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		ara <= {a, 2'b00};
		arv <= 1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 0;
		do @(posedge clk); while (rv !== 1'b1);
		rready <= 1;
		@(posedge clk);
		rready <= 0;
		chk(rd, e);
		chk({30'h0, rr}, {30'h0, er});
	endtask

	task automatic t_regs;
		for (int i = 0; i < 9; i++)
			rd_exp(ad_t[i], {24'h0, rs_t[i]}, 2'h0);
		chk({8'h0, cfg.gate_fine_level}, 32'h1A);
		chk({13'h0, cfg.gate_fine_hold}, 32'h4B0);
		for (int i = 0; i < 9; i++)
		begin
			bus_wr(ad_t[i], 8'hFF, 2'h0);
			rd_exp(ad_t[i], {24'h0, rs_t[i] | mk_t[i]}, 2'h0);
			bus_wr(ad_t[i], 8'h00, 2'h0);
			rd_exp(ad_t[i], {24'h0, rs_t[i] & ~mk_t[i]}, 2'h0);
		end
		bus_wr(8'h72, 8'h55, 2'h2);
		rd_exp(8'h72, 32'h0, 2'h2);
		ws <= 4'h0;
		bus_wr(8'h6C, 8'hA5, 2'h0);
		ws <= 4'hF;
		rd_exp(8'h6C, 32'h0, 2'h0);
		$display("test registers done");
	endtask

	task automatic t_fields;
		bus_wr(8'h6C, 8'h12, 2'h0);
		bus_wr(8'h6D, 8'h34, 2'h0);
		bus_wr(8'h6E, 8'h56, 2'h0);
		chk({8'h0, cfg.gate_fine_level}, 32'h123456);
		bus_wr(8'h6F, 8'h01, 2'h0);
		bus_wr(8'h70, 8'h2C, 2'h0);
		chk({13'h0, cfg.gate_fine_hold}, 32'h960);
		bus_wr(8'h71, 8'h3F, 2'h0);
		chk({26'h0, cfg.power_stage_lockout_level}, 32'h3F);
		for (logic [4:0] k = 0; k < 16; k++)
		begin
			rate <= k[3];
			bus_wr(8'h6B, {5'h0, k[2], 2'h3}, 2'h0);
			bus_wr(8'h6A, {k[1:0], 2'h1, k[3:0]}, 2'h0);
			chk({24'h0, dly}, {24'h0, dl_t[k[3:0]]});
			chk(32'(cfg.gate_fine_mode_enable), 32'(k[2]));
			chk(32'(cfg.low_signal_headroom_threshold), 32'(k[3:0]));
		end
		$display("test fields done");
	endtask

	task automatic t_misc;
		for (logic [2:0] b = 0; b < 4; b++)
		begin
			bsrc <= b[1];
			bus_wr(8'h6B, {1'b0, b[0], 6'h03}, 2'h0);
			chk({31'h0, batt}, {31'h0, b[1] & b[0]});
			chk(32'(cfg.battery_sample_enable), 32'(b[0]));
		end
		bus_wr(8'h73, 8'h20, 2'h0);
		chk({31'h0, cfg.dither_disable}, 32'h1);
		bus_wr(8'h73, 8'h00, 2'h0);
		chk(32'(cfg.dither_disable), 32'h0);
		for (logic [2:0] e = 0; e < 4; e++)
		begin
			ems <= e[1:0];
			rd_exp(8'h73, {24'h0, e[1:0], 6'h00}, 2'h0);
		end
		rst_n <= 0;
		@(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		rd_exp(8'h6E, 32'h1A, 2'h0);
		$display("test misc done");
	endtask

	task close_out;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		{rst_n, awv, wv, bready, arv, rready, rate, bsrc} = 8'h00;
		{awa, ara, wd, ems} = 54'h0;
		ws = 4'hF;
		fail_count = 0;
		samples_checked = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		t_regs;
		t_fields;
		t_misc;
		close_out;
	end
endmodule
